// ### rtl/sas_regs.vh
// register offsets, field positions, reset values and timing for the converter
`ifndef SAS_REGS_VH
`define SAS_REGS_VH
`define SAS_ADDR_MODE 16'hff80
`define SAS_ADDR_PIN_COUNT 16'hff84
`define SAS_ADDR_EDGE_MODE 16'hffed
`define SAS_RST_MODE 8'h01
`define SAS_RST_PIN_COUNT 8'h00
`define SAS_RST_EDGE_MODE 8'h00
`define SAS_PIN_COUNT_MASK 8'h0f
`define SAS_EDGE_MODE_MASK 8'h3f
`define SAS_MODE_ENABLE 7
`define SAS_MODE_TRIGGER 6
`define SAS_MODE_TIME_HI 5
`define SAS_MODE_TIME_LO 4
`define SAS_MODE_CH_HI 3
`define SAS_MODE_CH_LO 1
`define SAS_MODE_TIME_AUX 0
`define SAS_MAX_PINS 4'h8
`define SAS_EDGE_FALL 2'h0
`define SAS_EDGE_RISE 2'h1
`define SAS_EDGE_BOTH 2'h3
`define SAS_SAMPLE_SLOTS 2
`endif

// ### rtl/sas_edge_detect.v
// valid edge detector for one external input
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.vh"
module sas_edge_detect
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // pin and edge selection
   input wire pin_in,
   input wire [1:0] edge_sel,
   // detected edge
   output reg edge_pulse_ff
);
   reg prev_ff;
   reg nxt_edge_pulse;
   // previous pin level, reset high so no false rising edge
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         prev_ff <= 1'b1;
      else
         prev_ff <= pin_in;
   end
   // edge decode; prohibited code detects nothing
   always @*
   begin
      case (edge_sel)
         `SAS_EDGE_FALL: nxt_edge_pulse = prev_ff & ~pin_in;
         `SAS_EDGE_RISE: nxt_edge_pulse = ~prev_ff & pin_in;
         `SAS_EDGE_BOTH: nxt_edge_pulse = prev_ff ^ pin_in;
         default: nxt_edge_pulse = 1'b0;
      endcase
   end
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         edge_pulse_ff <= 1'b0;
      else
         edge_pulse_ff <= nxt_edge_pulse;
   end
endmodule
`default_nettype wire

// ### rtl/sas_pin_alloc.v
// analog/port allocation and pull-up gating for the eight shared pins
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.vh"
module sas_pin_alloc
(
   // pin count and pull-up request
   input wire [3:0] pin_count,
   input wire [7:0] pullup_req,
   // per-pin results
   output wire [7:0] analog_sel,
   output wire [7:0] pullup_en
);
   genvar i;
   // lowest n pins analog; codes above eight leave all digital
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_pin
         assign analog_sel[i] = (pin_count <= `SAS_MAX_PINS) &&
            (pin_count > i);
         assign pullup_en[i] = pullup_req[i] & ~analog_sel[i];
      end
   endgenerate
endmodule
`default_nettype wire

// ### rtl/sas_sequencer.v
// successive-approximation converter control with its registers
// ---------------------------------------------------------------
// Functional notes
// - pin count n makes lowest n pins analog; codes above 8 prohibited
// - pin count register clears to zero on reset
// - analog-allocated pins never get an internal pull-up
// - three 2-bit edge fields: fall, rise, prohibited, both
// - edge mode register clears to zero on reset
// - start sets top bit at half tap, keeps it if input above
// - each later bit set, kept if input at or above its tap
// - after bit 0, copy approximation to result and raise done
// - result is int(input/reference x 256 + 0.5)
// - result register undefined after reset
// - conversions run until enable clears; mode write restarts
// - trigger and enable set: wait for valid trigger edge
// - hardware mode returns to waiting after each conversion
// - hardware mode rewrite with enable aborts and awaits edge
// - mode write with enable clear halts at once, no result
// - software mode starts directly and repeats back to back
// - software mode rewrite with enable restarts on new channel
// - mode register resets to 01, fields enable/trigger/time/channel
// - time code sets conversion length of 40 to 200 cycles
// - done flag is a one-cycle pulse; a mode write suppresses it
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.vh"
module sas_sequencer
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // register access
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_ff,
   // oscillation mode select bit
   input wire clk_mode_sel,
   // external edge inputs
   input wire ext_trigger_input,
   input wire ext_irq_in_b,
   input wire ext_irq_in_c,
   // port pull-up option per pin
   input wire [7:0] port1_pullup_option,
   // analog macro: comparator says input at or above tap
   input wire cmp_above,
   output reg [7:0] tap_code_ff,
   output reg sample_ff,
   output reg [2:0] channel_ff,
   // pins
   output reg [7:0] analog_sel_ff,
   output reg [7:0] pullup_en_ff,
   // events
   output reg conversion_done_irq_ff,
   output reg [2:0] ext_edge_ff,
   output reg [7:0] conversion_result_ff
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_SAMPLE = 2'h2;
   localparam ST_BIT = 2'h3;
   reg rst_m_ff;
   reg rst_s_ff;
   wire rst_int_n;
   reg [7:0] converter_mode_reg_ff;
   reg [7:0] analog_pin_count_ff;
   reg [7:0] external_edge_mode_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [7:0] approx_register_ff;
   reg [7:0] nxt_approx;
   reg [2:0] bit_idx_ff;
   reg [2:0] nxt_bit_idx;
   reg [5:0] slot_cnt_ff; // six bits: two 20-cycle sampling slots reach 39
   reg [5:0] nxt_slot_cnt;
   reg done_pulse;
   wire mode_wr;
   wire [2:0] edge_pulse;
   wire [7:0] analog_sel;
   wire [7:0] pullup_en;
   wire [4:0] slot_len;
   wire enable_bit;
   wire trig_bit;
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_m_ff <= 1'b0;
         rst_s_ff <= 1'b0;
      end
      else
      begin
         rst_m_ff <= 1'b1;
         rst_s_ff <= rst_m_ff;
      end
   end
   assign rst_int_n = rst_s_ff;
   // ------------------------------------------------------------
   // conversion-time decode
   // ------------------------------------------------------------
   // cycles per slot; ten slots (two sampling, eight bits) per
   // conversion, so 40..200 cycles split evenly; prohibited codes
   // fall back to the longest to stay safe
   function [4:0] slot_cycles;
      input [2:0] code;
      input mcs;
      begin
         case (code)
            3'b001: slot_cycles = mcs ? 5'd8 : 5'd16;
            3'b011: slot_cycles = mcs ? 5'd4 : 5'd8;
            3'b100: slot_cycles = mcs ? 5'd5 : 5'd10;
            3'b101: slot_cycles = mcs ? 5'd10 : 5'd20;
            default: slot_cycles = 5'd20;
         endcase
      end
   endfunction
   assign enable_bit = converter_mode_reg_ff[`SAS_MODE_ENABLE];
   assign trig_bit = converter_mode_reg_ff[`SAS_MODE_TRIGGER];
   assign slot_len = slot_cycles({converter_mode_reg_ff[`SAS_MODE_TIME_HI],
      converter_mode_reg_ff[`SAS_MODE_TIME_LO],
      converter_mode_reg_ff[`SAS_MODE_TIME_AUX]}, clk_mode_sel);
   assign mode_wr = reg_wr && (reg_addr == `SAS_ADDR_MODE);
   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_edge
         sas_edge_detect u_edge
         (
            .clk_sys(clk_sys),
            .rst_n(rst_int_n),
            .pin_in(g == 0 ? ext_trigger_input :
               (g == 1 ? ext_irq_in_b : ext_irq_in_c)),
            .edge_sel(external_edge_mode_ff[2*g+1:2*g]),
            .edge_pulse_ff(edge_pulse[g])
         );
      end
   endgenerate
   sas_pin_alloc u_pins
   (
      .pin_count(analog_pin_count_ff[3:0]),
      .pullup_req(port1_pullup_option),
      .analog_sel(analog_sel),
      .pullup_en(pullup_en)
   );
   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         converter_mode_reg_ff <= `SAS_RST_MODE;
         analog_pin_count_ff <= `SAS_RST_PIN_COUNT;
         external_edge_mode_ff <= `SAS_RST_EDGE_MODE;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `SAS_ADDR_MODE)
            converter_mode_reg_ff <= reg_wdata;
         if (reg_addr == `SAS_ADDR_PIN_COUNT)
            analog_pin_count_ff <= reg_wdata & `SAS_PIN_COUNT_MASK;
         if (reg_addr == `SAS_ADDR_EDGE_MODE)
            external_edge_mode_ff <= reg_wdata & `SAS_EDGE_MODE_MASK;
      end
   end
   // read mux; unmapped addresses read zero
   always @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
         reg_rdata_ff <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `SAS_ADDR_MODE: reg_rdata_ff <= converter_mode_reg_ff;
            `SAS_ADDR_PIN_COUNT: reg_rdata_ff <= analog_pin_count_ff;
            `SAS_ADDR_EDGE_MODE: reg_rdata_ff <= external_edge_mode_ff;
            default: reg_rdata_ff <= 8'h00;
         endcase
      end
   end
   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // a mode write always reinitialises; the new enable and trigger
   // bits decide where the sequence goes next
   always @*
   begin
      nxt_state = state_ff;
      nxt_approx = approx_register_ff;
      nxt_bit_idx = bit_idx_ff;
      nxt_slot_cnt = slot_cnt_ff;
      done_pulse = 1'b0;
      if (mode_wr)
      begin
         nxt_slot_cnt = 6'd0;
         nxt_bit_idx = 3'd7;
         nxt_approx = 8'h00;
         if (!reg_wdata[`SAS_MODE_ENABLE])
            nxt_state = ST_IDLE;
         else if (reg_wdata[`SAS_MODE_TRIGGER])
            nxt_state = ST_WAIT;
         else
            nxt_state = ST_SAMPLE;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               nxt_slot_cnt = 6'd0;
            end
            ST_WAIT:
            begin
               nxt_slot_cnt = 6'd0;
               if (edge_pulse[0])
                  nxt_state = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
               // sampling lasts two bit slots
               if (slot_cnt_ff == {slot_len, 1'b0} - 6'd1)
               begin
                  nxt_slot_cnt = 6'd0;
                  nxt_bit_idx = 3'd7;
                  nxt_approx = 8'h80;
                  nxt_state = ST_BIT;
               end
               else
                  nxt_slot_cnt = slot_cnt_ff + 6'd1;
            end
            ST_BIT:
            begin
               if (slot_cnt_ff == {1'b0, slot_len} - 6'd1)
               begin
                  nxt_slot_cnt = 6'd0;
                  // keep trial bit when input at or above tap
                  nxt_approx[bit_idx_ff] = cmp_above;
                  if (bit_idx_ff == 3'd0)
                  begin
                     done_pulse = 1'b1;
                     nxt_bit_idx = 3'd7;
                     nxt_state = trig_bit ? ST_WAIT : ST_SAMPLE;
                  end
                  else
                  begin
                     nxt_bit_idx = bit_idx_ff - 3'd1;
                     nxt_approx[bit_idx_ff - 3'd1] = 1'b1;
                  end
               end
               else
                  nxt_slot_cnt = slot_cnt_ff + 6'd1;
            end
            default:
            begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end
   always @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         state_ff <= ST_IDLE;
         approx_register_ff <= 8'h00;
         bit_idx_ff <= 3'd7;
         slot_cnt_ff <= 6'd0;
      end
      else
      begin
         state_ff <= nxt_state;
         approx_register_ff <= nxt_approx;
         bit_idx_ff <= nxt_bit_idx;
         slot_cnt_ff <= nxt_slot_cnt;
      end
   end
   // result register has no reset: its content is undefined at start
   always @(posedge clk_sys)
   begin
      if (done_pulse)
         conversion_result_ff <= nxt_approx;
   end
   // ------------------------------------------------------------
   // outputs to analog macro, pins and interrupt logic
   // ------------------------------------------------------------
   // done flag follows done_pulse, a one-cycle pulse that a mode write in the same cycle suppresses
   always @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         conversion_done_irq_ff <= 1'b0;
         ext_edge_ff <= 3'h0;
         tap_code_ff <= 8'h00;
         sample_ff <= 1'b0;
         channel_ff <= 3'h0;
         analog_sel_ff <= 8'h00;
         pullup_en_ff <= 8'h00;
      end
      else
      begin
         conversion_done_irq_ff <= done_pulse;
         ext_edge_ff <= edge_pulse;
         tap_code_ff <= nxt_approx;
         sample_ff <= (nxt_state == ST_SAMPLE);
         channel_ff <= converter_mode_reg_ff[`SAS_MODE_CH_HI:`SAS_MODE_CH_LO];
         analog_sel_ff <= analog_sel;
         pullup_en_ff <= pullup_en;
      end
   end
endmodule
`default_nettype wire

// ### tb/sas_adc_model.sv
// analog front-end model: ideal comparator over a per-channel level table
`timescale 1ns/1ps
`default_nettype none
module sas_adc_model
(
   // trial code and selected channel from the sequencer
   input wire logic [7:0] tap_code_ff,
   input wire logic [2:0] channel_ff,
   // input level of channel i as an ideal code in bits 8i+7:8i
   input wire logic [63:0] level_tbl,
   // comparator answer
   output logic cmp_above
);
   // a tie counts as above, so the converted code equals the level
   assign cmp_above = level_tbl[channel_ff*8 +: 8] >= tap_code_ff;
endmodule
`default_nettype wire

// ### tb/sas_sequencer_properties.sv
// assertions on the converter's top-level ports
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_properties
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register access
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   // pins, analog macro and events
   input wire logic ext_trigger_input,
   input wire logic [7:0] tap_code_ff,
   input wire logic sample_ff,
   input wire logic [7:0] analog_sel_ff,
   input wire logic [7:0] pullup_en_ff,
   input wire logic conversion_done_irq_ff,
   input wire logic [2:0] ext_edge_ff
);
   // ---------------------------------------------------------------
   // helper state and properties
   // ---------------------------------------------------------------
   logic hw_ff;
   logic [7:0] cnt_ff;
   wire mode_wr = reg_wr && reg_addr == 16'hff80;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // trigger-mode shadow; cycles since sampling ended, saturating
   always @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
      begin
         hw_ff <= 1'b0;
         cnt_ff <= 8'h00;
      end
      else
      begin
         if (mode_wr)
            hw_ff <= reg_wdata[7] & reg_wdata[6];
         cnt_ff <= sample_ff ? 8'h00 : cnt_ff + {7'h0, cnt_ff != 8'hff};
      end
   AST_PIN_MASK: assert property (((analog_sel_ff + 8'h01) & analog_sel_ff)
      == 8'h00) else $error("analog pins not a low block");
   AST_PULLUP_OFF: assert property ((pullup_en_ff & analog_sel_ff) == 8'h00)
      else $error("pull-up on analog pin");
   AST_PINCOUNT_RD: assert property (reg_rd && reg_addr == 16'hff84 |=>
      reg_rdata_ff[7:4] == 4'h0) else $error("pin count upper bits set");
   AST_MSB_TRIAL: assert property ($fell(sample_ff) && !$past(reg_wr) |->
      ##[0:1] tap_code_ff == 8'h80) else $error("first trial not half tap");
   AST_STOP_QUIET: assert property (mode_wr && !reg_wdata[7] |->
      ##2 !conversion_done_irq_ff [*8]) else $error("result after stop");
   AST_SW_START: assert property (mode_wr && reg_wdata[7:6] == 2'h2 |->
      ##[1:4] sample_ff) else $error("software start missing");
   AST_HW_WAIT: assert property ($rose(sample_ff) && hw_ff |->
      ext_edge_ff[0] || $past(ext_edge_ff[0]))
      else $error("start without trigger");
   AST_EDGE_CAUSE: assert property (ext_edge_ff[0] |->
      $past(ext_trigger_input, 2) != $past(ext_trigger_input, 3))
      else $error("edge pulse without pin change");
   AST_DONE_LATE: assert property (conversion_done_irq_ff |->
      cnt_ff >= 8'h3c) else $error("conversion too short");
   // main scenarios seen
   cover property (conversion_done_irq_ff && hw_ff);
   cover property (conversion_done_irq_ff && !hw_ff);
   cover property (ext_edge_ff == 3'h7);
endmodule
bind sas_sequencer sas_sequencer_properties u_props (.*);
`default_nettype wire

// ### tb/sar_adc_sequencer_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_test;
   logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clk_mode_sel = 1;
   logic ext_trigger_input = 1, ext_irq_in_b = 1, ext_irq_in_c = 1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00, port1_pullup_option = 8'h00, d;
   logic [7:0] reg_rdata_ff, tap_code_ff, analog_sel_ff, pullup_en_ff;
   logic [7:0] conversion_result_ff;
   logic [63:0] level_tbl = 64'h0;
   logic [2:0] channel_ff, ext_edge_ff, acc;
   logic cmp_above, sample_ff, conversion_done_irq_ff;
   int error_cnt = 0, checks_done = 0, n, ch;
   // allowed time codes as {oscillation mode, code} nibbles
   logic [23:0] tsel = 24'h9134d5;
   sas_sequencer uut (.*);
   sas_adc_model model (.*);
   // ---------------------------------------------------------------
   // clock, bus and comparison helpers
   // ---------------------------------------------------------------
   initial
      forever #10 clk_sys = ~clk_sys;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // inputs always move 1 ns after the edge, never on it
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      tick(1);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1;
      tick(1);
      reg_wr = 0;
   endtask
   task automatic rd_reg(input logic [15:0] a);
      tick(1);
      reg_addr = a;
      reg_rd = 1;
      tick(1);
      reg_rd = 0;
      d = reg_rdata_ff;
   endtask
   // n reaches lim when no done pulse came
   task automatic wait_done(input int lim);
      n = 0;
      do
      begin
         tick(1);
         n++;
      end
      while (n < lim && conversion_done_irq_ff !== 1'b1);
   endtask
   task automatic trig_pulse;
      ext_trigger_input = 0;
      tick(3);
      ext_trigger_input = 1;
   endtask
   function automatic logic [7:0] amask(input int k);
      return k > 8 ? 8'h00 : 8'((16'h1 << k) - 16'h1);
   endfunction
   // conversion length in clocks per time code; short mode halves it
   function automatic int conv_len(input logic [2:0] code, input logic mcs);
      int base;
      case (code)
         3'b001: base = 80;
         3'b011: base = 40;
         3'b100: base = 50;
         default: base = 100;
      endcase
      return mcs ? base : 2 * base;
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      tick(5);
      rst_n = 1;
      tick(3);
      void'($urandom(93));
      rd_reg(16'hff80);
      check(d, 8'h01);
      rd_reg(16'hff84);
      check(d, 8'h00);
      rd_reg(16'hffed);
      check(d, 8'h00);
      rd_reg(16'hff00);
      check(d, 8'h00);
      // every pin count code, prohibited ones included
      for (int i = 0; i < 16; i++)
      begin
         port1_pullup_option = 8'($urandom);
         wr_reg(16'hff84, {4'($urandom), i[3:0]});
         rd_reg(16'hff84);
         check(d, {4'h0, i[3:0]});
         check(analog_sel_ff, amask(i));
         check(pullup_en_ff, port1_pullup_option & ~amask(i));
      end
      // every edge code on all three inputs, falling then rising
      for (int c = 0; c < 4; c++)
      begin
         wr_reg(16'hffed, {2'($urandom), {3{c[1:0]}}});
         rd_reg(16'hffed);
         check(d, {2'h0, {3{c[1:0]}}});
         for (int l = 0; l < 2; l++)
         begin
            {ext_trigger_input, ext_irq_in_b, ext_irq_in_c} = {3{l[0]}};
            acc = 3'h0;
            repeat (4)
            begin
               tick(1);
               acc |= ext_edge_ff;
            end
            check({5'h0, acc}, {5'h0, {3{c == 3 || c == l}}});
         end
      end
      level_tbl = {$urandom, $urandom};
      level_tbl[7:0] = 8'h00;
      level_tbl[63:56] = 8'hff;
      wr_reg(16'hff84, 8'h08);
      for (int k = 0; k < 4; k++)
      begin
         ch = $urandom % 8;
         wr_reg(16'hff80, 8'h81 | {4'h0, ch[2:0], 1'b0});
         wait_done(300);
         check(conversion_result_ff, level_tbl[ch*8 +: 8]);
         wait_done(300);
         check(8'(n), 8'h50);
      end
      // rewrite mid-conversion moves to the new channel at once
      wr_reg(16'hff80, 8'h83);
      tick(30);
      wr_reg(16'hff80, 8'h8f);
      wait_done(300);
      check(conversion_result_ff, level_tbl[63:56]);
      check(8'(n > 77 && n < 85), 8'h01);
      tick(30);
      wr_reg(16'hff80, 8'h0f);
      wait_done(200);
      check(8'(n), 8'hc8);
      wr_reg(16'hffed, 8'h00);
      wr_reg(16'hff80, 8'hc5);
      wait_done(150);
      check(8'(n), 8'h96);
      trig_pulse;
      wait_done(300);
      check(conversion_result_ff, level_tbl[23:16]);
      wait_done(150);
      check(8'(n), 8'h96);
      trig_pulse;
      tick(30);
      wr_reg(16'hff80, 8'hcb);
      wait_done(150);
      check(8'(n), 8'h96);
      trig_pulse;
      wait_done(300);
      check(conversion_result_ff, level_tbl[47:40]);
      // each allowed time code, 001 and 101 in both oscillation modes, back to back
      for (int t = 0; t < 6; t++)
      begin
         clk_mode_sel = tsel[t*4+3];
         wr_reg(16'hff80, {2'h2, tsel[t*4+1 +: 2], 3'h0, tsel[t*4]});
         wait_done(450);
         wait_done(450);
         check(8'(n), 8'(conv_len(tsel[t*4 +: 3], tsel[t*4+3])));
      end
      wr_reg(16'hff80, 8'h01);
      tally_and_finish;
   end
   // hang guard, well past the few thousand cycles the run needs
   initial
   begin
      tick(30000);
      error_cnt++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
